/* logic/i2c_slave_address_and_transfer.sv */
// two-wire bus slave: address detection, receive and transmit, behind AHB-Lite
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

module i2c_slave_address_and_transfer
	import i2c_slave_pkg::*;
#(
	parameter int HADDR_W = 8	// bus address width seen by the slave
)
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [HADDR_W-1:0] haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire logic               scl_in,
	output logic                    scl_out,
	output logic                    scl_oe,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	output logic                    slave_event_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// the map needs five words, offsets up to 0x10
	if (HADDR_W < 5)
	begin : g_bad_width
		$error("haddr too narrow for the register map");
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// word decode, shared by write and read paths
	function automatic reg_id_t reg_sel(input logic [HADDR_W-1:0] a);
		logic [7:0] low;
		low = 8'(a);
		if (a != HADDR_W'(low))
			return REG_NONE;	// above the map
		unique case (low)
			OFF_CONTROL:  return REG_CONTROL;
			OFF_STATUS:   return REG_STATUS;
			OFF_ADDRESS:  return REG_ADDRESS;
			OFF_TRANSMIT: return REG_TRANSMIT;
			OFF_RECEIVE:  return REG_RECEIVE;
			default:      return REG_NONE;	// unmapped reads zero
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	state_t st_r;	// all flip-flops of the block
	state_t st_nxt;	// next value of all of them

	logic   take;	// address phase accepted
	logic   scl_rise;	// serial clock rising edge
	logic   scl_fall;	// serial clock falling edge
	logic   start_seen;	// data falls while clock high
	logic   stop_seen;	// data rises while clock high
	logic   hi_match;	// ten-bit head byte matches
	logic   lo_match;	// second byte or 7-bit match
	logic [7:0] byte_in;	// byte as completed at eighth rise

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	// bus slave, pin sampling and serial engine in one pass
	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.irq = 1'b0;	// event is a one-cycle pulse

		// two flops before anything looks at a pin
		st_nxt.scl.meta = scl_in;
		st_nxt.scl.sync = st_r.scl.meta;
		st_nxt.scl.prev = st_r.scl.sync;
		st_nxt.sda.meta = sda_in;
		st_nxt.sda.sync = st_r.sda.meta;
		st_nxt.sda.prev = st_r.sda.sync;

		scl_rise   = st_r.scl.sync & ~st_r.scl.prev;
		scl_fall   = ~st_r.scl.sync & st_r.scl.prev;
		start_seen = st_r.scl.sync & st_r.scl.prev & st_r.sda.prev & ~st_r.sda.sync;
		stop_seen  = st_r.scl.sync & st_r.scl.prev & ~st_r.sda.prev & st_r.sda.sync;
		byte_in    = {st_r.rsr[6:0], st_r.sda.sync};
		hi_match   = (byte_in[7:3] == TEN_BIT_PREFIX) && (byte_in[2:1] == st_r.saddr[9:8]);
		lo_match   = st_r.control[CTL_TEN_BIT] ? (byte_in == st_r.saddr[7:0])
			: (byte_in[7:1] == st_r.saddr[6:0]);

		// zero-wait slave, always OKAY
		st_nxt.hreadyout = 1'b1;
		st_nxt.hresp     = 1'b0;
		take             = hsel & htrans[1] & hready;

		// data phase of a write
		if (st_r.wr.pend)
		begin
			unique case (st_r.wr.target)
				REG_CONTROL:
				begin
					st_nxt.control = hwdata[15:0];
					// release may be set freely; clearing needs stretch enable
					st_nxt.control[CTL_RELEASE] = hwdata[CTL_RELEASE]
						| (st_r.control[CTL_RELEASE] & ~st_r.control[CTL_STRETCH]);
				end
				REG_STATUS:
					st_nxt.status[15:STAT_RO_BITS] = hwdata[15:STAT_RO_BITS];
				REG_ADDRESS:
					st_nxt.saddr = hwdata[9:0];
				REG_TRANSMIT:
				begin
					st_nxt.txr                  = hwdata[7:0];
					st_nxt.status[STAT_TX_FULL] = 1'b1;
				end
				REG_NONE, REG_RECEIVE: ;	// ignored
			endcase
		end
		st_nxt.wr.pend   = take & hwrite;
		st_nxt.wr.target = take ? reg_sel(haddr) : REG_NONE;

		// read data registered at the address phase, after any write above
		if (take & ~hwrite)
		begin
			unique case (reg_sel(haddr))
				REG_CONTROL:  st_nxt.hrdata = {16'h0000, st_nxt.control};
				REG_STATUS:   st_nxt.hrdata = {16'h0000, st_nxt.status};
				REG_ADDRESS:  st_nxt.hrdata = {22'h0, st_nxt.saddr};
				REG_TRANSMIT: st_nxt.hrdata = {24'h000000, st_nxt.txr};
				REG_RECEIVE:
				begin
					st_nxt.hrdata               = {24'h000000, st_nxt.rxbuf};
					st_nxt.status[STAT_RX_FULL] = 1'b0;	// reading empties it
				end
				REG_NONE:     st_nxt.hrdata = 32'h00000000;
			endcase
		end

		// serial engine; its sets come after software clears so sets win
		if (!st_r.control[CTL_ENABLE])
		begin
			st_nxt.mode   = ST_IDLE;
			st_nxt.bcnt   = 4'h0;
			st_nxt.sda_oe = 1'b0;
			st_nxt.prior  = 1'b0;
			st_nxt.pend_load = 1'b0;
		end
		else if (stop_seen)
		begin
			// stop ends everything, including a remembered full match
			st_nxt.mode               = ST_IDLE;
			st_nxt.bcnt               = 4'h0;
			st_nxt.sda_oe             = 1'b0;
			st_nxt.prior              = 1'b0;
			st_nxt.pend_load          = 1'b0;
			st_nxt.status[STAT_STOP]  = 1'b1;
			st_nxt.status[STAT_START] = 1'b0;
		end
		else if (start_seen)
		begin
			// start or repeated start; nothing shifts before this
			st_nxt.mode               = ST_ADDR;
			st_nxt.bcnt               = 4'h0;
			st_nxt.sda_oe             = 1'b0;
			st_nxt.pend_load          = 1'b0;
			st_nxt.status[STAT_START] = 1'b1;
			st_nxt.status[STAT_STOP]  = 1'b0;
			st_nxt.status[STAT_DATA]  = 1'b0;
		end
		else if (st_r.mode != ST_IDLE && st_r.mode != ST_WAIT)
		begin
			// rising clock: take a bit in
			if (scl_rise)
			begin
				if (st_r.bcnt < BITS_PER_BYTE)
					st_nxt.rsr = byte_in;
				else
					st_nxt.ack_in = ~st_r.sda.sync;	// master acknowledge
				st_nxt.bcnt = st_r.bcnt + 4'h1;
				// eighth bit: judge the byte now, act on the falls
				if (st_r.bcnt == BITS_PER_BYTE - 4'h1)
				begin
					st_nxt.ack_drv = 1'b0;
					st_nxt.irq_due = 1'b0;
					st_nxt.go      = ST_WAIT;
					unique case (st_r.mode)
						ST_ADDR:
						begin
							st_nxt.status[STAT_READ] = byte_in[0];
							if (!st_r.control[CTL_TEN_BIT])
							begin
								// buffer untouched by a match
								st_nxt.ack_drv = lo_match;
								st_nxt.irq_due = lo_match;
								st_nxt.go      = !lo_match ? ST_WAIT : (byte_in[0] ? ST_TX : ST_RX);
							end
							else if (hi_match && !byte_in[0])
							begin
								st_nxt.ack_drv = 1'b1;
								st_nxt.irq_due = 1'b1;
								st_nxt.go      = ST_ADDR2;
								st_nxt.status[STAT_FULL_ADR] = 1'b0;
							end
							else if (hi_match && st_r.prior)
							begin
								// repeated start after a full match: head byte is enough
								st_nxt.ack_drv = 1'b1;
								st_nxt.irq_due = 1'b1;
								st_nxt.go      = ST_TX;
							end
							else
							begin
								st_nxt.status[STAT_FULL_ADR] = 1'b0;
								st_nxt.prior                 = 1'b0;
							end
						end
						ST_ADDR2:
						begin
							st_nxt.ack_drv = lo_match;
							st_nxt.irq_due = lo_match;
							st_nxt.go      = lo_match ? ST_RX : ST_WAIT;
							st_nxt.prior   = lo_match;
							st_nxt.status[STAT_FULL_ADR] = lo_match;
						end
						ST_RX:
						begin
							st_nxt.irq_due           = 1'b1;
							st_nxt.go                = ST_RX;
							st_nxt.status[STAT_DATA] = 1'b1;
							if (!st_nxt.status[STAT_RX_FULL])
							begin
								// load even with overflow pending, but refuse it
								st_nxt.rxbuf                 = byte_in;
								st_nxt.status[STAT_RX_FULL]  = 1'b1;
								st_nxt.ack_drv               = ~st_nxt.status[STAT_OVERFLOW];
							end
							else
								st_nxt.status[STAT_OVERFLOW] = 1'b1;
						end
						ST_TX:
						begin
							// only the master acknowledges here
							st_nxt.irq_due           = 1'b1;
							st_nxt.go                = ST_TX;
							st_nxt.status[STAT_DATA] = 1'b1;
						end
						ST_IDLE, ST_WAIT: ;	// excluded above
					endcase
				end
			end

			// falling clock: drive or release data
			if (scl_fall)
			begin
				if (st_r.bcnt == BITS_PER_BYTE)
					st_nxt.sda_oe = st_r.ack_drv;
				else if (st_r.bcnt == ACK_CLOCK)
				begin
					// end of the ninth clock
					st_nxt.sda_oe = 1'b0;
					st_nxt.bcnt   = 4'h0;
					st_nxt.irq    = st_r.irq_due;
					st_nxt.mode   = st_r.go;
					if (st_r.go == ST_TX && st_r.mode == ST_TX && !st_r.ack_in)
						st_nxt.mode = ST_WAIT;	// master done reading
					else if (st_r.go == ST_TX)
					begin
						if (st_nxt.status[STAT_TX_FULL])
						begin
							// loaded in time: no stretch
							// next value, so a transmit write in this very cycle is not lost
							st_nxt.tsr                  = st_nxt.txr;
							st_nxt.status[STAT_TX_FULL] = 1'b0;
							st_nxt.sda_oe               = ~st_nxt.txr[7];
						end
						else
						begin
							// stretch whatever stretch enable says
							st_nxt.control[CTL_RELEASE] = 1'b0;
							st_nxt.pend_load            = 1'b1;
						end
					end
				end
				else if (st_r.mode == ST_TX && st_r.bcnt != 4'h0)
				begin
					// next bit goes out while clock is low
					st_nxt.tsr    = {st_r.tsr[6:0], 1'b0};
					st_nxt.sda_oe = ~st_r.tsr[6];
				end
			end

			// software released the held clock: load and go
			if (st_r.mode == ST_TX && st_r.pend_load && st_r.control[CTL_RELEASE])
			begin
				// clock is let go as the release write lands, data loads one cycle later; the master's rise comes later
				st_nxt.tsr                  = st_nxt.txr;
				st_nxt.status[STAT_TX_FULL] = 1'b0;
				st_nxt.sda_oe               = ~st_nxt.txr[7];
				st_nxt.pend_load            = 1'b0;
			end
		end

		// held clock: transmit waiting for software
		st_nxt.scl_oe = (st_nxt.mode == ST_TX) & st_nxt.pend_load & ~st_nxt.control[CTL_RELEASE];
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	// all state in one flop bank; reset to constants only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r           <= '0;
			st_r.hreadyout <= 1'b1;
			st_r.scl       <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1};	// idle bus is high
			st_r.sda       <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1};
			st_r.control   <= CONTROL_RESET;
			st_r.status    <= STATUS_RESET;
			st_r.saddr     <= ADDRESS_RESET;
			st_r.mode      <= ST_IDLE;
			st_r.go        <= ST_IDLE;
			st_r.wr.target <= REG_NONE;
		end
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	// every output is a flop; pins only ever pull low
	assign hreadyout       = st_r.hreadyout;
	assign hresp           = st_r.hresp;
	assign hrdata          = st_r.hrdata;
	assign scl_out         = st_r.irq & 1'b0;
	assign sda_out         = st_r.irq & 1'b0;
	assign scl_oe          = st_r.scl_oe;
	assign sda_oe          = st_r.sda_oe;
	assign slave_event_irq = st_r.irq;

endmodule

/* logic/i2c_slave_pkg.sv */
// shared constants and types of the two-wire slave with its register bus
package i2c_slave_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFF_CONTROL  = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_ADDRESS  = 8'h08;
	localparam logic [7:0] OFF_TRANSMIT = 8'h0c;
	localparam logic [7:0] OFF_RECEIVE  = 8'h10;

	// control_word field positions
	localparam int CTL_ENABLE   = 15;
	localparam int CTL_RELEASE  = 12;
	localparam int CTL_TEN_BIT  = 10;
	localparam int CTL_STRETCH  = 6;

	// status_word field positions; bits below STAT_RO_BITS are read-only
	localparam int STAT_TX_FULL  = 0;
	localparam int STAT_RX_FULL  = 1;
	localparam int STAT_READ     = 2;
	localparam int STAT_START    = 3;
	localparam int STAT_STOP     = 4;
	localparam int STAT_DATA     = 5;
	localparam int STAT_RO_BITS  = 6;
	localparam int STAT_OVERFLOW = 6;
	localparam int STAT_FULL_ADR = 8;

	// reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET  = 16'h0000;
	localparam logic [9:0]  ADDRESS_RESET = 10'h000;

	// protocol figures
	localparam logic [4:0] TEN_BIT_PREFIX = 5'b11110;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam logic [3:0] ACK_CLOCK      = 4'h9;

	// register selected by a bus address
	typedef enum logic [2:0] {REG_NONE, REG_CONTROL, REG_STATUS, REG_ADDRESS, REG_TRANSMIT, REG_RECEIVE} reg_id_t;

	// where the serial engine stands
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR2, ST_RX, ST_TX, ST_WAIT} mode_t;

	// pending write data phase
	typedef struct packed {
		logic    pend;
		reg_id_t target;
	} bus_phase_t;

	// two-stage synchroniser plus history for one pin
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} pin_sync_t;

	// whole state of the block
	typedef struct packed {
		bus_phase_t  wr;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
		pin_sync_t   scl;
		pin_sync_t   sda;
		logic [15:0] control;
		logic [15:0] status;
		logic [9:0]  saddr;
		logic [7:0]  txr;
		logic [7:0]  rxbuf;
		logic [7:0]  rsr;
		logic [7:0]  tsr;
		logic [3:0]  bcnt;
		mode_t       mode;
		mode_t       go;
		logic        ack_drv;
		logic        ack_in;
		logic        irq_due;
		logic        prior;
		logic        pend_load;
		logic        sda_oe;
		logic        scl_oe;
		logic        irq;
	} state_t;

endpackage

/* testbench/bus_master.sv */
// behavioural master on the two serial lines
`timescale 1ns/1ps
module bus_master
(
	input  wire logic scl,	// wired clock level
	input  wire logic sda,	// wired data level
	output logic      scl_low,	// high pulls clock down
	output logic      sda_low	// high pulls data down
);
	// lines released at power up
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// one clock pulse; a stretched clock is waited out, bounded
	task automatic pulse(output logic seen);
		#40;
		scl_low = 1'b0;
		for (int i = 0; i < 20000 && scl !== 1'b1; i++)
			#4;
		#40;
		seen = sda;
		#40;
		scl_low = 1'b1;
		#40;
	endtask
	// start or repeated start: data falls while clock high
	task automatic start();
		sda_low = 1'b0;
		#40;
		scl_low = 1'b0;
		#40;
		sda_low = 1'b1;
		#40;
		scl_low = 1'b1;
	endtask
	// stop: data rises while clock high
	task automatic stop();
		sda_low = 1'b1;
		#40;
		scl_low = 1'b0;
		#40;
		sda_low = 1'b0;
		#80;
	endtask
	// byte out msb first, then the slave's answer
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int k = 7; k >= 0; k--)
		begin
			sda_low = ~d[k];
			pulse(s);
		end
		sda_low = 1'b0;
		pulse(s);
		ack = ~s;
	endtask
	// byte in msb first, then our answer
	task automatic rbyte(input logic give_ack, output logic [7:0] d);
		logic s;
		sda_low = 1'b0;
		for (int k = 7; k >= 0; k--)
		begin
			pulse(s);
			d[k] = s;
		end
		sda_low = give_ack;
		pulse(s);
		sda_low = 1'b0;
	endtask
endmodule

/* testbench/i2c_slave_address_and_transfer_chk.sv */
// port-level assertions on the slave
`timescale 1ns/1ps
module i2c_slave_chk
	import i2c_slave_pkg::*;
#(
	parameter int HADDR_W = 8
)
(
	input wire logic               hclk,
	input wire logic               hresetn,
	input wire logic               hsel,
	input wire logic [HADDR_W-1:0] haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic               hreadyout,
	input wire logic               hresp,
	input wire logic               scl_in,
	input wire logic               scl_out,
	input wire logic               scl_oe,
	input wire logic               sda_out,
	input wire logic               sda_oe,
	input wire logic               slave_event_irq
);
	logic ctl_wr_r;	// control write now in its data phase
	// track control writes so release can be tied to them
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			ctl_wr_r <= 1'b0;
		else
			ctl_wr_r <= hsel && htrans[1] && hwrite && hready && haddr == HADDR_W'(OFF_CONTROL);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not zero wait okay");
	AST_SCL_OPEN_DRAIN: assert property (!scl_out) else $error("clock driven high");
	AST_SDA_OPEN_DRAIN: assert property (!sda_out) else $error("data driven high");
	AST_IRQ_ONE_CYCLE: assert property (slave_event_irq |=> !slave_event_irq) else $error("event too long");
	AST_IRQ_CLOCK_LOW: assert property (slave_event_irq |-> !scl_in) else $error("event off clock low");
	AST_SDA_MOVES_LOW: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved clock high");
	AST_STRETCH_LOW: assert property ($rose(scl_oe) |-> !scl_in) else $error("stretch while high");
	AST_RELEASE_FREES: assert property (ctl_wr_r && hwdata[CTL_RELEASE] |-> ##[1:4] !scl_oe)
		else $error("release ignored");
endmodule
bind i2c_slave_address_and_transfer i2c_slave_chk #(.HADDR_W(HADDR_W)) chk_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe), .slave_event_irq(slave_event_irq));

/* testbench/i2c_slave_address_and_transfer_test.sv */
// bench: register tasks and serial transfers against the slave
`timescale 1ns/1ps
module i2c_slave_address_and_transfer_test
	import i2c_slave_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hready;	// slave answer fed back as bus ready
	logic [31:0] hrdata;
	logic        hresp, scl_oe, sda_oe, scl_out, sda_out, irq, m_scl, m_sda, ack;
	logic        scl_in = 1'b1;	// pin levels as the slave samples them
	logic        sda_in = 1'b1;
	logic [31:0] rd;
	logic [7:0]  b;
	int          fail_count = 0;
	int          check_count = 0;
	int          irq_n = 0;	// event pulses seen
	wire         scl_w = ~(scl_oe | m_scl);	// pull-up unless pulled low
	wire         sda_w = ~(sda_oe | m_sda);
	always #2 hclk = ~hclk;
	// pins reach the slave on the clock edge; count events
	always @(posedge hclk)
	begin
		scl_in <= scl_w;
		sda_in <= sda_w;
		if (irq === 1'b1)
			irq_n++;
	end
	i2c_slave_address_and_transfer i2c_slave_address_and_transfer_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .scl_in(scl_in), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .slave_event_irq(irq));
	bus_master bus_master_i (.scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// single word: address phase, then data phase; read data at its end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask
	// bounded wait for the stretch output to reach a level
	task automatic wait_oe(input logic v);
		for (int n = 0; n < 3000 && scl_oe !== v; n++)
			@(posedge hclk);
		chk("scl_oe", 32'(scl_oe), 32'(v));
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("control", OFF_CONTROL, 32'h0);
		rdchk("status", OFF_STATUS, 32'h0);
		rdchk("address", OFF_ADDRESS, 32'h0);
		rdchk("unmapped", 8'h14, 32'h0);
		xfer(1'b1, OFF_STATUS, 32'hffff);
		rdchk("status", OFF_STATUS, 32'hffc0);
		xfer(1'b1, OFF_STATUS, 32'h0);
		xfer(1'b1, OFF_ADDRESS, 32'h2a);
		xfer(1'b1, OFF_CONTROL, 32'h8000);
		// 7-bit receive with full buffer and stale overflow
		bus_master_i.start();
		bus_master_i.wbyte(8'h54, ack);
		chk("addr ack", 32'(ack), 32'h1);
		xfer(1'b0, OFF_STATUS, 32'h0);
		chk("rx full", 32'(rd[STAT_RX_FULL]), 32'h0);
		bus_master_i.wbyte(8'h5a, ack);
		chk("ack", 32'(ack), 32'h1);
		rdchk("receive", OFF_RECEIVE, 32'h5a);
		bus_master_i.wbyte(8'h11, ack);
		bus_master_i.wbyte(8'h22, ack);
		chk("full nack", 32'(ack), 32'h0);
		xfer(1'b0, OFF_STATUS, 32'h0);
		chk("overflow", 32'(rd[STAT_OVERFLOW]), 32'h1);
		rdchk("receive", OFF_RECEIVE, 32'h11);
		bus_master_i.wbyte(8'h33, ack);
		chk("overflow nack", 32'(ack), 32'h0);
		rdchk("receive", OFF_RECEIVE, 32'h33);
		bus_master_i.stop();
		chk("events", 32'(irq_n), 32'h5);
		xfer(1'b1, OFF_STATUS, 32'h0);
		bus_master_i.start();
		bus_master_i.wbyte(8'h56, ack);
		chk("other addr", 32'(ack), 32'h0);
		bus_master_i.stop();
		// 7-bit transmit: stretch, release, early load
		bus_master_i.start();
		bus_master_i.wbyte(8'h55, ack);
		chk("read ack", 32'(ack), 32'h1);
		fork
			bus_master_i.rbyte(1'b1, b);
			begin
				wait_oe(1'b1);
				xfer(1'b1, OFF_TRANSMIT, 32'ha5);
				xfer(1'b1, OFF_CONTROL, 32'h9000);
			end
		join
		chk("tx byte", 32'(b), 32'ha5);
		wait_oe(1'b1);
		rdchk("control", OFF_CONTROL, 32'h8000);
		fork
			bus_master_i.rbyte(1'b1, b);
			begin
				xfer(1'b1, OFF_TRANSMIT, 32'h3c);
				xfer(1'b1, OFF_CONTROL, 32'h9000);
				wait_oe(1'b0);
				xfer(1'b1, OFF_TRANSMIT, 32'h77);
			end
		join
		chk("tx byte", 32'(b), 32'h3c);
		rdchk("control", OFF_CONTROL, 32'h9000);
		bus_master_i.rbyte(1'b0, b);
		chk("tx byte", 32'(b), 32'h77);
		bus_master_i.stop();
		chk("events", 32'(irq_n), 32'h9);
		// 10-bit: head, low byte, data, repeated start read
		xfer(1'b1, OFF_ADDRESS, 32'h2a5);
		// stretch enable on here: transmit must stretch all the same
		xfer(1'b1, OFF_CONTROL, 32'h8440);
		bus_master_i.start();
		bus_master_i.wbyte(8'hf4, ack);
		chk("head ack", 32'(ack), 32'h1);
		bus_master_i.wbyte(8'ha5, ack);
		chk("low ack", 32'(ack), 32'h1);
		xfer(1'b0, OFF_STATUS, 32'h0);
		chk("full match", 32'(rd[STAT_FULL_ADR]), 32'h1);
		bus_master_i.wbyte(8'h66, ack);
		rdchk("receive", OFF_RECEIVE, 32'h66);
		bus_master_i.start();
		bus_master_i.wbyte(8'hf5, ack);
		chk("restart ack", 32'(ack), 32'h1);
		fork
			bus_master_i.rbyte(1'b0, b);
			begin
				wait_oe(1'b1);
				rdchk("control", OFF_CONTROL, 32'h8440);
				xfer(1'b1, OFF_TRANSMIT, 32'h99);
				xfer(1'b1, OFF_CONTROL, 32'h9400);
			end
		join
		chk("tx byte", 32'(b), 32'h99);
		// head byte with wrong upper bits: no ack, full match dropped
		bus_master_i.start();
		bus_master_i.wbyte(8'hf0, ack);
		chk("head miss", 32'(ack), 32'h0);
		xfer(1'b0, OFF_STATUS, 32'h0);
		chk("full match", 32'(rd[STAT_FULL_ADR]), 32'h0);
		bus_master_i.stop();
		wrap_up();
	end
	// hang guard, well past the expected run
	initial
	begin
		#300000;
		fail_count++;
		wrap_up();
	end
endmodule
